// >>> srcc_clkgen_model.sv
// srcc_clkgen_model.sv: free-running sample clock and sysref source model
`timescale 1ns/10ps
`default_nettype none
module srcc_clkgen_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // requested sysref level
    input wire logic req_lvl,
    // pins towards the device
    output logic sample_clk,
    output logic sysref
);
    logic [2:0] ph_q;
    // ============================================================
    // sample clock: eight clk_sys per half period, slow as required
    // sysref moves mid half-period so no sampling edge ever races it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ph_q <= 3'h0;
            sample_clk <= 1'b0;
            sysref <= 1'b0;
        end else begin
            ph_q <= ph_q + 3'h1;
            if (ph_q == 3'h7) sample_clk <= ~sample_clk;
            if (ph_q == 3'h3) sysref <= req_lvl;
        end
    end
endmodule
`default_nettype wire

// >>> srcc_defines.svh
// srcc_defines.svh: offsets, fields, reset values of the capture control
`ifndef SRCC_DEFINES_SVH
`define SRCC_DEFINES_SVH
// ============================================================
// register indices (byte address is four times the index)
`define SRCC_CTRL1_IDX 12'h120
`define SRCC_CTRL2_IDX 12'h121
`define SRCC_STAT_IDX 12'h12f
// ============================================================
// control 1 fields
`define SRCC_FLAGRST_BIT 6
`define SRCC_TRANS_BIT 4
`define SRCC_EDGE_BIT 3
`define SRCC_MODE_MSB 2
`define SRCC_MODE_LSB 1
`define SRCC_CTRL1_WMASK 8'h5e
// control 2 fields
`define SRCC_IGN_MSB 3
`define SRCC_CTRL2_WMASK 8'h0f
// ============================================================
// reset values and mode codes
`define SRCC_CTRL1_RST 8'h00
`define SRCC_CTRL2_RST 8'h00
`define SRCC_MODE_OFF 2'h0
`define SRCC_MODE_CONT 2'h1
`define SRCC_MODE_NSHOT 2'h2
// ============================================================
// bus answers
`define SRCC_RESP_OKAY 2'h0
`define SRCC_RESP_DECERR 2'h3
`endif

// >>> srcc_edge_det.sv
// srcc_edge_det.sv: two-flop synchroniser with edge detection
`timescale 1ns/10ps
`default_nettype none
module srcc_edge_det (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // asynchronous pin
    input wire logic din,
    // synchronised outputs
    srcc_edge_if.src ev
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // ============================================================
    // synchroniser: meta_q feeds sync_q only
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // edges flagged in the same cycle the synchronised level moves
    assign ev.level = sync_q;
    assign ev.rise = sync_q & ~prev_q;
    assign ev.fall = ~sync_q & prev_q;
endmodule
`default_nettype wire

// >>> srcc_edge_if.sv
// srcc_edge_if.sv: synchronised level and edge strobes of one pin
`timescale 1ns/10ps
`default_nettype none
interface srcc_edge_if;
    logic level;
    logic rise;
    logic fall;
    modport src (output level, output rise, output fall);
    modport snk (input level, input rise, input fall);
endinterface
`default_nettype wire

// >>> srcc_pkg.sv
// srcc_pkg.sv: types of the capture control
package srcc_pkg;
    // ============================================================
    // n-shot sequencer states
    typedef enum logic [2:0] {
        SHOT_IDLE  = 3'b001,
        SHOT_ARMED = 3'b010,
        SHOT_DONE  = 3'b100
    } srcc_shot_e;
    typedef logic [1:0] srcc_mode_t;
    typedef logic [3:0] srcc_count_t;
endpackage

// >>> srcc_top.sv
// srcc_top.sv: sysref capture control with an axi4-lite register slave
// Contract
// [RQ1] select 1: only falling sysref transitions count
// [RQ2] software disables capture before changing polarity
// [RQ3] edge bit picks rising or falling clock
// [RQ4] ignore count zero acts on next transition
// [RQ5] count n skips n transitions, then acts
// [RQ6] mode: off, continuous, or n-shot
// [RQ7] select 0: only rising sysref transitions count
`timescale 1ns/10ps
`default_nettype none
`include "srcc_defines.svh"
module srcc_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // axi4-lite write address
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // timing pins and captured pulse
    input wire logic sysref_in,
    input wire logic sample_clk_in,
    output logic sysref_pulse
);
    logic aw_hold_q, w_hold_q, w_lane0_q, bvalid_q, rvalid_q;
    logic [15:0] aw_addr_q;
    logic [7:0] w_byte_q, ctrl1_q, ctrl2_q, fire_cnt_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic do_write, wr_ctrl1, wr_ctrl2, wr_hit, rearm, fire, pulse_q;
    logic trans_sel, edge_sel, sample_evt, sref_now, sref_smp_q, valid_evt;
    srcc_pkg::srcc_mode_t mode;
    srcc_pkg::srcc_count_t ign, seen_q;
    srcc_pkg::srcc_shot_e shot_q;

    srcc_edge_if clk_ev ();
    srcc_edge_if sref_ev ();

    // ============================================================
    // pin synchronisers
    srcc_edge_det u_clk_det (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .din(sample_clk_in),
        .ev(clk_ev)
    );
    srcc_edge_det u_sref_det (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .din(sysref_in),
        .ev(sref_ev)
    );

    // ============================================================
    // address decode: word index in addr[13:2], upper bits zero
    function automatic logic idx_hit(input logic [15:0] a,
                                     input logic [11:0] idx);
        idx_hit = (a[15:14] == 2'h0) && (a[13:2] == idx);
    endfunction

    // ============================================================
    // write channel: address and data taken in either order
    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready = !w_hold_q && !bvalid_q;
    assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
    assign wr_ctrl1 = do_write && w_lane0_q
                      && idx_hit(aw_addr_q, `SRCC_CTRL1_IDX);
    assign wr_ctrl2 = do_write && w_lane0_q
                      && idx_hit(aw_addr_q, `SRCC_CTRL2_IDX);
    assign wr_hit = idx_hit(aw_addr_q, `SRCC_CTRL1_IDX)
                    || idx_hit(aw_addr_q, `SRCC_CTRL2_IDX)
                    || idx_hit(aw_addr_q, `SRCC_STAT_IDX);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= 16'h0000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            w_hold_q <= 1'b0;
            w_byte_q <= 8'h00;
            w_lane0_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            w_byte_q <= s_axi_wdata[7:0];
            w_lane0_q <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_hold_q <= 1'b0;
        end
    end

    // response one cycle after both halves are held
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= `SRCC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? `SRCC_RESP_OKAY : `SRCC_RESP_DECERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ============================================================
    // configuration registers; reserved bits stay zero
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl1_q <= `SRCC_CTRL1_RST;
        end else if (wr_ctrl1) begin
            ctrl1_q <= w_byte_q & `SRCC_CTRL1_WMASK;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl2_q <= `SRCC_CTRL2_RST;
        end else if (wr_ctrl2) begin
            ctrl2_q <= w_byte_q & `SRCC_CTRL2_WMASK;
        end
    end
    assign mode = ctrl1_q[`SRCC_MODE_MSB:`SRCC_MODE_LSB];
    assign trans_sel = ctrl1_q[`SRCC_TRANS_BIT];
    assign edge_sel = ctrl1_q[`SRCC_EDGE_BIT];
    assign ign = ctrl2_q[`SRCC_IGN_MSB:0];

    // ============================================================
    // read channel: data registered, answer one cycle after address
    assign s_axi_arready = !rvalid_q;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rresp_q <= `SRCC_RESP_OKAY;
            rdata_q <= 32'h00000000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= `SRCC_RESP_OKAY;
            if (idx_hit(s_axi_araddr, `SRCC_CTRL1_IDX)) begin
                rdata_q <= {24'h000000, ctrl1_q};
            end else if (idx_hit(s_axi_araddr, `SRCC_CTRL2_IDX)) begin
                rdata_q <= {24'h000000, ctrl2_q};
            end else if (idx_hit(s_axi_araddr, `SRCC_STAT_IDX)) begin
                rdata_q <= {16'h0000, fire_cnt_q, 1'b0,
                            shot_q == srcc_pkg::SHOT_DONE,
                            shot_q == srcc_pkg::SHOT_ARMED,
                            sref_smp_q, seen_q};
            end else begin
                rdata_q <= 32'h00000000;
                rresp_q <= `SRCC_RESP_DECERR;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // ============================================================
    // sampling: sysref taken on the selected sample-clock edge
    assign sample_evt = edge_sel ? clk_ev.fall : clk_ev.rise; // [RQ3]
    assign sref_now = sref_ev.level;

    // tracked in every mode so enabling never sees a stale edge;
    // a polarity change while enabled may fake one event [RQ2]
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sref_smp_q <= 1'b0;
        end else if (sample_evt) begin
            sref_smp_q <= sref_now;
        end
    end

    // valid transition of the selected polarity
    assign valid_evt = sample_evt && (trans_sel
        ? (sref_smp_q && !sref_now)   // [RQ1]
        : (!sref_smp_q && sref_now)); // [RQ7]

    // ============================================================
    // n-shot sequencer; any config write re-arms it
    assign rearm = wr_ctrl1 || wr_ctrl2;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            shot_q <= srcc_pkg::SHOT_IDLE;
            seen_q <= 4'h0;
        end else if (rearm || mode != `SRCC_MODE_NSHOT) begin
            shot_q <= srcc_pkg::SHOT_ARMED;
            seen_q <= 4'h0;
        end else begin
            unique case (shot_q)
                srcc_pkg::SHOT_IDLE: begin
                    shot_q <= srcc_pkg::SHOT_ARMED;
                end
                srcc_pkg::SHOT_ARMED: begin
                    if (valid_evt && seen_q == ign) begin
                        shot_q <= srcc_pkg::SHOT_DONE; // [RQ4]
                    end else if (valid_evt) begin
                        seen_q <= seen_q + 4'h1; // [RQ5]
                    end
                end
                srcc_pkg::SHOT_DONE: begin
                    shot_q <= srcc_pkg::SHOT_DONE;
                end
            endcase
        end
    end

    // mode 11 acts as disabled
    always_comb begin
        unique case (mode)
            `SRCC_MODE_CONT: fire = valid_evt; // [RQ6]
            `SRCC_MODE_NSHOT: fire = valid_evt && !rearm
                && shot_q == srcc_pkg::SHOT_ARMED && seen_q == ign; // [RQ6]
            default: fire = 1'b0; // [RQ6]
        endcase
    end

    // registered one-cycle pulse to the link timing logic
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pulse_q <= 1'b0;
            fire_cnt_q <= 8'h00;
        end else begin
            pulse_q <= fire;
            fire_cnt_q <= fire_cnt_q + {7'h00, fire};
        end
    end
    assign sysref_pulse = pulse_q;

    // ============================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_cont_event;
        mode == `SRCC_MODE_CONT && valid_evt;
    endsequence
    sequence s_shot_ready;
        mode == `SRCC_MODE_NSHOT && !rearm
            && shot_q == srcc_pkg::SHOT_ARMED;
    endsequence

    chk_fall_only: assert property ( // [RQ1]
        s_cont_event and (trans_sel) |->
            (sref_smp_q && !sref_now) ##1 sysref_pulse)
        else $error("falling event wrong or not acted on");
    chk_rise_only: assert property ( // [RQ7]
        (mode == `SRCC_MODE_CONT && sample_evt && !trans_sel
            && !(!sref_smp_q && sref_now)) |=> !sysref_pulse)
        else $error("pulse on non-rising transition");
    chk_edge_pick: assert property ( // [RQ3]
        sample_evt |-> (edge_sel ? (!clk_ev.level && $past(clk_ev.level))
                                 : (clk_ev.level && !$past(clk_ev.level))))
        else $error("sysref sampled on wrong clock edge");
    chk_next_shot: assert property ( // [RQ4]
        (s_shot_ready and (ign == 4'h0 && valid_evt)) |=>
            (sysref_pulse && shot_q == srcc_pkg::SHOT_DONE))
        else $error("n-shot with zero count missed event");
    chk_skip_count: assert property ( // [RQ5]
        (s_shot_ready and (valid_evt && seen_q != ign)) |=>
            !sysref_pulse && seen_q == $past(seen_q) + 4'h1)
        else $error("n-shot acted before count expired");
    chk_mode_off: assert property ( // [RQ6]
        (mode != `SRCC_MODE_CONT && mode != `SRCC_MODE_NSHOT)
            |=> !sysref_pulse)
        else $error("pulse while capture disabled");
    chk_shot_once: assert property ( // [RQ6]
        (mode == `SRCC_MODE_NSHOT && shot_q == srcc_pkg::SHOT_DONE
            && !rearm) |=> !sysref_pulse)
        else $error("n-shot fired twice");
endmodule
`default_nettype wire

// >>> tb.sv
// tb.sv: self-checking bench of the sysref capture control
`timescale 1ns/10ps
`default_nettype none
`include "srcc_defines.svh"
module tb;
    localparam logic [15:0] A1 = {2'b00, `SRCC_CTRL1_IDX, 2'b00};
    localparam logic [15:0] A2 = {2'b00, `SRCC_CTRL2_IDX, 2'b00};
    localparam logic [15:0] A3 = {2'b00, `SRCC_STAT_IDX, 2'b00};
    localparam logic [15:0] ABAD = 16'h0500;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] awaddr = 16'h0, araddr = 16'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, req = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, pulse, sclk, sref;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, d;
    logic m_ed = 1'b0, m_tr = 1'b0, m_done = 1'b0;
    logic [1:0] m_md = 2'h0;
    int m_n = 0, m_ign = 0, m_exp = 0, got = 0, n_fail = 0, checks_done = 0;
    int n, m_tot = 0;
    always #25 clk_sys = ~clk_sys;
    srcc_clkgen_model i_gen (.clk_sys(clk_sys), .rst_n(rst_n),
        .req_lvl(req), .sample_clk(sclk), .sysref(sref));
    srcc_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sysref_in(sref), .sample_clk_in(sclk), .sysref_pulse(pulse));
    // ============================================================
    // compare and verdict
    task automatic chk_val(input logic [31:0] g, e, input string m);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic chk_cnt(input int g, e, input string m);
        checks_done++;
        if (g != e) begin
            n_fail++;
            $display("MISMATCH %0t %s got %0d exp %0d", $time, m, g, e);
        end
    endtask
    task automatic end_of_test();
        if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ============================================================
    // axi4-lite master: each channel released at its own handshake
    task automatic wr(input logic [15:0] a, input logic [31:0] v,
                      input logic [1:0] er);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk_sys);
            if (!aw && awready === 1'b1) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w && wready === 1'b1) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk_sys); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk_val({30'h0, bresp}, {30'h0, er}, "bresp");
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] ev,
                      input logic [1:0] er);
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk_sys); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk_sys); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk_val(rdata, ev, "rdata");
        chk_val({30'h0, rresp}, {30'h0, er}, "rresp");
    endtask
    // ============================================================
    // configure: capture off before polarity moves, then enable
    task automatic cfg(input logic ed, tr, input logic [1:0] md, input int k);
        wr(A1, {27'h0, m_tr, m_ed, 3'h0}, `SRCC_RESP_OKAY);
        wr(A1, {27'h0, tr, ed, 3'h0}, `SRCC_RESP_OKAY);
        wr(A2, 32'(k), `SRCC_RESP_OKAY);
        wr(A1, {27'h0, tr, ed, md, 1'b0}, `SRCC_RESP_OKAY);
        m_ed = ed;
        m_tr = tr;
        m_md = md;
        m_n = k;
        m_ign = 0;
        m_done = 1'b0;
        m_exp = 0;
        got = 0;
    endtask
    // toggle sysref k times; the model counts the expected pulses
    task automatic tog(input int k);
        logic nv;
        for (int i = 0; i < k; i++) begin
            nv = ~req;
            req <= nv;
            if (nv != m_tr && m_md == `SRCC_MODE_CONT) m_exp++;
            else if (nv != m_tr && m_md == `SRCC_MODE_NSHOT && !m_done) begin
                if (m_ign < m_n) m_ign++;
                else begin
                    m_exp++;
                    m_done = 1'b1;
                end
            end
            repeat (40) @(posedge clk_sys);
        end
        m_tot += m_exp;
        chk_cnt(got, m_exp, "pulse count");
    endtask
    // pulse follows the chosen sample clock edge by three cycles
    always @(posedge clk_sys) begin
        if (pulse === 1'b1) begin
            got++;
            chk_val({31'h0, sclk}, {31'h0, ~m_ed}, "edge");
        end
    end
    // ============================================================
    // main sequence
    initial begin
        void'($urandom(32'hfc57efae));
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(A1, 32'h0, `SRCC_RESP_OKAY);
        rd(A2, 32'h0, `SRCC_RESP_OKAY);
        d = $urandom;
        wr(A2, d, `SRCC_RESP_OKAY);
        rd(A2, d & 32'h0f, `SRCC_RESP_OKAY);
        // polarity moves while capture is off, enabled only afterwards
        wr(A1, d & 32'hfffffff9, `SRCC_RESP_OKAY);
        wr(A1, d, `SRCC_RESP_OKAY);
        rd(A1, d & 32'h5e, `SRCC_RESP_OKAY);
        m_tr = d[4];
        m_ed = d[3];
        wr(A3, d, `SRCC_RESP_OKAY);
        wr(ABAD, d, `SRCC_RESP_DECERR);
        rd(ABAD, 32'h0, `SRCC_RESP_DECERR);
        for (int i = 0; i < 4; i++) begin
            cfg(i[0], i[1], `SRCC_MODE_CONT, 0);
            tog(6);
        end
        cfg(1'b0, 1'b0, `SRCC_MODE_OFF, 0);
        tog(4);
        cfg(1'b1, 1'b0, 2'h3, 0);
        tog(4);
        for (int i = 0; i < 3; i++) begin
            n = (i == 0) ? 0 : (i == 1) ? 1 + $urandom % 14 : 15;
            cfg(i == 1, i != 0, `SRCC_MODE_NSHOT, n);
            tog(2 * n + 4);
            // status: pulse total, done, level low, n ignored
            rd(A3, {16'h0, 8'(m_tot), 4'h4, 4'(n)}, `SRCC_RESP_OKAY);
        end
        end_of_test();
    end
    // hang guard: the whole run needs well under this span
    initial begin
        repeat (40000) @(posedge clk_sys);
        n_fail++;
        end_of_test();
    end
endmodule
`default_nettype wire
